/* File: src/dorb_bank.sv */
/*
 * Drive object register bank: exchange arrays, debug text buffer, customer
 * storage, restart control and the drive submode word, reached entry by entry
 * through the dictionary access port.
 * Assumes one request per cycle at most, inputs synchronous to clock_i, and
 * a user program side that reads and writes its arrays through plain ports.
 */
`timescale 1ns/1ps
module dorb_bank
   import dorb_pkg::*;
#(
   parameter int CYC_MS = CYC_PER_MS
) (
   input  wire logic       clock_i,
   input  wire logic       reset_i,
   input  wire logic       od_req_i,
   input  wire dorb_req_t  od_cmd_i,
   output dorb_rsp_t       od_rsp_o,
   input  wire logic [4:0] prog_in_addr_i,
   output logic [31:0]     prog_in_data_o,
   input  wire logic [4:0] prog_init_addr_i,
   output logic [31:0]     prog_init_data_o,
   input  wire logic       prog_out_we_i,
   input  wire logic [4:0] prog_out_addr_i,
   input  wire logic [31:0] prog_out_data_i,
   input  wire logic [7:0] prog_store_addr_i,
   output logic [31:0]     prog_store_data_o,
   input  wire logic       dbg_push_i,
   input  wire logic [7:0] dbg_byte_i,
   output logic            dbg_full_o,
   output logic            reboot_o,
   output logic            reboot_pending_o,
   output logic            winding_short_en_o,
   input  wire logic       torque_mode_i,
   output logic            loop_closure_select_o,
   output logic            ramp_speed_emulation_o,
   output logic            auto_brake_en_o,
   output logic            current_reduction_enable_o,
   output logic            torque_only_o,
   output logic            brushless_motor_select_o
);

   // ************************************************************
   // Decode helpers.
   // ************************************************************

   // Returns the highest subindex of an entry, zero for unknown ones.
   function automatic logic [7:0] last_sub(input logic [15:0] idx);
      unique case (idx)
         IDX_INPUTS, IDX_INIT, IDX_OUTPUTS: last_sub = XCHG_LAST;
         IDX_DEBUG:   last_sub = DEBUG_LAST;
         IDX_STORE:   last_sub = STORE_LAST;
         IDX_REBOOT:  last_sub = REBOOT_LAST;
         default:     last_sub = SUB_COUNT;
      endcase
   endfunction

   // Tells whether an index belongs to this bank.
   function automatic logic known(input logic [15:0] idx);
      known = (last_sub(idx) != SUB_COUNT) || (idx == IDX_SUBMODE);
   endfunction

   // ************************************************************
   // Request check.
   // ************************************************************
   logic [15:0] idx;
   logic [7:0]  sub;
   logic [7:0]  sub_m1;
   logic        is_count;
   logic        item_ok;
   logic        wr_ok;
   logic        pdo_ok;
   logic        accept;
   logic        wr_acc;

   assign idx    = od_cmd_i.index;
   assign sub    = od_cmd_i.sub;
   assign sub_m1 = sub - 8'h01;

   // Checks range, access right and process data mapping of the entry.
   always_comb begin
      is_count = (sub == SUB_COUNT) && (idx != IDX_SUBMODE);
      item_ok  = known(idx) && (sub <= last_sub(idx));
      // Only the debug count and the submode word are writable at subindex 0; debug bytes are read-only.
      wr_ok    = is_count ? ((idx == IDX_DEBUG) && (od_cmd_i.wdata <= 32'(DEBUG_DEPTH)))
                          : (idx != IDX_DEBUG);
      // Receive mapping for inputs, init and submode; transmit for outputs.
      if (is_count) begin
         pdo_ok = 1'b0;
      end else if (od_cmd_i.wr) begin
         pdo_ok = (idx == IDX_INPUTS) || (idx == IDX_INIT)
               || (idx == IDX_SUBMODE);
      end else begin
         pdo_ok = (idx == IDX_OUTPUTS);
      end
      accept = od_req_i && item_ok && (!od_cmd_i.wr || wr_ok)
            && (!od_cmd_i.pdo || pdo_ok);
      wr_acc = accept && od_cmd_i.wr;
   end

   // ************************************************************
   // Exchange arrays and customer storage.
   // ************************************************************
   logic [31:0] in_rd;
   logic [31:0] init_rd;
   logic [31:0] out_rd;
   logic [31:0] store_rd;

   // Inputs pass from the bus to the user program only.
   dorb_word_array #(.DEPTH(XCHG_DEPTH), .AW(5)) u_inputs (
      .clock_i    (clock_i),                        .reset_i    (reset_i),
      .bus_we_i   (wr_acc && (idx == IDX_INPUTS)),  .bus_addr_i (sub_m1[4:0]),
      .bus_wdata_i(od_cmd_i.wdata),                 .bus_rdata_o(in_rd),
      .usr_we_i   (1'b0),                           .usr_addr_i (prog_in_addr_i),
      .usr_wdata_i(WORD_RESET),                     .usr_rdata_o(prog_in_data_o)
   );

   // Init parameters mirror the inputs; saving is done by the storage agent.
   dorb_word_array #(.DEPTH(XCHG_DEPTH), .AW(5)) u_init (
      .clock_i    (clock_i),                        .reset_i    (reset_i),
      .bus_we_i   (wr_acc && (idx == IDX_INIT)),    .bus_addr_i (sub_m1[4:0]),
      .bus_wdata_i(od_cmd_i.wdata),                 .bus_rdata_o(init_rd),
      .usr_we_i   (1'b0),                           .usr_addr_i (prog_init_addr_i),
      .usr_wdata_i(WORD_RESET),                     .usr_rdata_o(prog_init_data_o)
   );

   // Outputs carry user program results back to the bus.
   dorb_word_array #(.DEPTH(XCHG_DEPTH), .AW(5)) u_outputs (
      .clock_i    (clock_i),                        .reset_i    (reset_i),
      .bus_we_i   (wr_acc && (idx == IDX_OUTPUTS)), .bus_addr_i (sub_m1[4:0]),
      .bus_wdata_i(od_cmd_i.wdata),                 .bus_rdata_o(out_rd),
      .usr_we_i   (prog_out_we_i),                  .usr_addr_i (prog_out_addr_i),
      .usr_wdata_i(prog_out_data_i),                .usr_rdata_o()
   );

   // Customer storage words.
   dorb_word_array #(.DEPTH(STORE_DEPTH), .AW(8)) u_store (
      .clock_i    (clock_i),                        .reset_i    (reset_i),
      .bus_we_i   (wr_acc && (idx == IDX_STORE)),   .bus_addr_i (sub_m1),
      .bus_wdata_i(od_cmd_i.wdata),                 .bus_rdata_o(store_rd),
      .usr_we_i   (1'b0),                           .usr_addr_i (prog_store_addr_i),
      .usr_wdata_i(WORD_RESET),                     .usr_rdata_o(prog_store_data_o)
   );

   // ************************************************************
   // Debug text buffer.
   // ************************************************************
   logic [7:0] dbg_mem_ff [DEBUG_DEPTH];
   logic [6:0] dbg_cnt_ff;
   logic [6:0] dbg_base;
   logic       dbg_cnt_we;

   assign dbg_cnt_we = wr_acc && (idx == IDX_DEBUG);
   assign dbg_base   = dbg_cnt_we ? od_cmd_i.wdata[6:0] : dbg_cnt_ff;
   assign dbg_full_o = (dbg_cnt_ff == 7'(DEBUG_DEPTH));

   // A push in the cycle the count is written lands after the new count.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         dbg_cnt_ff <= '0;
      end else if (dbg_push_i && (dbg_base < 7'(DEBUG_DEPTH))) begin
         dbg_cnt_ff <= dbg_base + 7'h01;
      end else begin
         dbg_cnt_ff <= dbg_base;
      end
   end

   // Stores the printed bytes; only the user program writes them.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         for (int i = 0; i < DEBUG_DEPTH; i++) begin
            dbg_mem_ff[i] <= BYTE_RESET;
         end
      end else if (dbg_push_i && (dbg_base < 7'(DEBUG_DEPTH))) begin
         dbg_mem_ff[dbg_base[5:0]] <= dbg_byte_i;
      end
   end

   // ************************************************************
   // Restart and boot-loader settings.
   // ************************************************************
   logic [31:0] rb_cmd_ff;
   logic [31:0] rb_delay_ff;
   logic [31:0] rb_hw_ff;
   logic        rb_magic;

   assign rb_magic = wr_acc && (idx == IDX_REBOOT) && (sub == SUB_RB_CMD)
                  && (od_cmd_i.wdata == REBOOT_MAGIC);

   // Keeps the three words; any command value is stored as written.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         rb_cmd_ff   <= WORD_RESET;
         rb_delay_ff <= WORD_RESET;
         rb_hw_ff    <= WORD_RESET;
      end else if (wr_acc && (idx == IDX_REBOOT)) begin
         // Only subindices 01h to 03h pass the write check, so one item always matches.
         unique case (sub)
            SUB_RB_CMD:   rb_cmd_ff   <= od_cmd_i.wdata;
            SUB_RB_DELAY: rb_delay_ff <= od_cmd_i.wdata;
            SUB_RB_HW:    rb_hw_ff    <= od_cmd_i.wdata;
         endcase
      end
   end

   // Waits out the delay before the restart pulse.
   dorb_reboot_timer #(.CYC_MS(CYC_MS)) u_timer (
      .clock_i   (clock_i),     .reset_i(reset_i),          .start_i(rb_magic),
      .delay_ms_i(rb_delay_ff), .busy_o (reboot_pending_o), .fire_o (reboot_o)
   );

   // Set bit 0 switches winding shorting off.
   assign winding_short_en_o = !rb_hw_ff[HW_NOSHORT];

   // ************************************************************
   // Drive submode word.
   // ************************************************************
   logic [31:0] sm_ff;

   // Holds only the defined bits; the rest stay zero.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         sm_ff <= WORD_RESET;
      end else if (wr_acc && (idx == IDX_SUBMODE)) begin
         sm_ff <= od_cmd_i.wdata & SM_DEFINED;
      end
   end

   // Drives the control selections from the stored word.
   assign loop_closure_select_o      = sm_ff[SM_LOOP];
   assign ramp_speed_emulation_o     = sm_ff[SM_RAMP];
   assign auto_brake_en_o            = sm_ff[SM_BRAKE];
   assign current_reduction_enable_o = sm_ff[SM_CURRENT_REDUCTION_ENABLE] && !sm_ff[SM_LOOP];
   assign torque_only_o              = sm_ff[SM_TORQUE] && torque_mode_i;
   assign brushless_motor_select_o   = sm_ff[SM_BRUSHLESS_MOTOR_SELECT];

   // ************************************************************
   // Answer.
   // ************************************************************
   logic [31:0] rd_mux;

   // Picks the read value of the addressed entry.
   always_comb begin
      rd_mux = WORD_RESET;
      if (is_count) begin
         rd_mux = (idx == IDX_DEBUG) ? 32'(dbg_cnt_ff) : 32'(last_sub(idx));
      end else begin
         unique case (idx)
            IDX_INPUTS:  rd_mux = in_rd;
            IDX_INIT:    rd_mux = init_rd;
            IDX_OUTPUTS: rd_mux = out_rd;
            IDX_DEBUG:   rd_mux = 32'(dbg_mem_ff[sub_m1[5:0]]);
            IDX_STORE:   rd_mux = store_rd;
            IDX_SUBMODE: rd_mux = sm_ff;
            IDX_REBOOT:  rd_mux = (sub == SUB_RB_CMD) ? rb_cmd_ff
                                : ((sub == SUB_RB_DELAY) ? rb_delay_ff : rb_hw_ff);
            default:     rd_mux = WORD_RESET;
         endcase
      end
   end

   // Answers every request one cycle later; refusals carry the error flag.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         od_rsp_o <= '0;
      end else begin
         od_rsp_o.ack   <= od_req_i;
         od_rsp_o.err   <= od_req_i && !accept;
         od_rsp_o.rdata <= (accept && !od_cmd_i.wr) ? rd_mux : WORD_RESET;
      end
   end

   // ************************************************************
   // Assertions.
   // ************************************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);

   sequence s_magic_nodelay;
      rb_magic && (rb_delay_ff == WORD_RESET);
   endsequence

   sequence s_pending_then_fire;
      reboot_pending_o ##1 reboot_o;
   endsequence

   in_pdo_write_a: assert property (
      (od_req_i && od_cmd_i.wr && od_cmd_i.pdo && (idx == IDX_INPUTS)
       && (sub != SUB_COUNT) && (sub <= XCHG_LAST))
      |=> (od_rsp_o.ack && !od_rsp_o.err))
      else $error("input pdo write refused");

   init_write_read_a: assert property (
      (od_req_i && od_cmd_i.wr && (idx == IDX_INIT) && (sub == 8'h01))
      ##1 (od_req_i && !od_cmd_i.wr && !od_cmd_i.pdo && (idx == IDX_INIT) && (sub == 8'h01))
      |=> (od_rsp_o.rdata == $past(od_cmd_i.wdata, 2)))
      else $error("init parameter lost");

   out_pdo_dir_a: assert property (
      (od_req_i && od_cmd_i.pdo && (idx == IDX_OUTPUTS)
       && (sub != SUB_COUNT) && (sub <= XCHG_LAST))
      |=> (od_rsp_o.err == $past(od_cmd_i.wr)))
      else $error("output pdo direction wrong");

   ctrl_isolated_a: assert property (
      !(wr_acc && (idx == IDX_SUBMODE)) |=> $stable(sm_ff))
      else $error("submode changed without a write");

   dbg_readonly_a: assert property (
      (od_req_i && od_cmd_i.wr && (idx == IDX_DEBUG) && (sub != SUB_COUNT))
      |=> od_rsp_o.err)
      else $error("debug byte write accepted");

   store_range_a: assert property (
      (od_req_i && (idx == IDX_STORE) && (sub == 8'hff)) |=> od_rsp_o.err)
      else $error("storage subindex 255 accepted");

   magic_fire_a: assert property (
      s_magic_nodelay |=> s_pending_then_fire)
      else $error("zero delay restart not after two cycles");

   plain_cmd_a: assert property (
      (wr_acc && (idx == IDX_REBOOT) && (sub == SUB_RB_CMD)
       && (od_cmd_i.wdata != REBOOT_MAGIC) && !reboot_pending_o && !reboot_o)
      |=> (!reboot_pending_o && !reboot_o))
      else $error("restart from non magic value");

   winding_a: assert property (
      (wr_acc && (idx == IDX_REBOOT) && (sub == SUB_RB_HW))
      |=> (winding_short_en_o == !$past(od_cmd_i.wdata[0])))
      else $error("winding shorting bit wrong");

   loop_sel_a: assert property (
      (wr_acc && (idx == IDX_SUBMODE))
      |=> (loop_closure_select_o == $past(od_cmd_i.wdata[0])))
      else $error("loop closure not taken from bit 0");

   sm_unused_a: assert property (
      (accept && !od_cmd_i.wr && (idx == IDX_SUBMODE))
      |=> ((od_rsp_o.rdata & ~SM_DEFINED) == WORD_RESET))
      else $error("unused submode bits read non zero");

endmodule

/* File: src/dorb_pkg.sv */
/*
 * Shared constants and types of the drive object register bank: dictionary
 * indices and subindex limits, field positions, reset values, timing and the
 * request and answer carriers.
 * Assumes a single 40 MHz clock and a dictionary access port that carries one
 * entry per request.
 */
package dorb_pkg;

   // ************************************************************
   // Dictionary indices and subindex limits.
   // ************************************************************
   localparam logic [15:0] IDX_INPUTS   = 16'h2400;
   localparam logic [15:0] IDX_INIT     = 16'h2410;
   localparam logic [15:0] IDX_OUTPUTS  = 16'h2500;
   localparam logic [15:0] IDX_DEBUG    = 16'h2600;
   localparam logic [15:0] IDX_STORE    = 16'h2701;
   localparam logic [15:0] IDX_REBOOT   = 16'h2800;
   localparam logic [15:0] IDX_SUBMODE  = 16'h3202;
   localparam logic [7:0]  SUB_COUNT    = 8'h00;
   localparam logic [7:0]  XCHG_LAST    = 8'h20;
   localparam logic [7:0]  DEBUG_LAST   = 8'h40;
   localparam logic [7:0]  STORE_LAST   = 8'hfe;
   localparam logic [7:0]  REBOOT_LAST  = 8'h03;
   localparam logic [7:0]  SUB_RB_CMD   = 8'h01;
   localparam logic [7:0]  SUB_RB_DELAY = 8'h02;
   localparam logic [7:0]  SUB_RB_HW    = 8'h03;

   // ************************************************************
   // Values, field positions and sizes.
   // ************************************************************
   localparam logic [31:0] REBOOT_MAGIC = 32'h746f_6f62;
   localparam logic [31:0] WORD_RESET   = 32'h0000_0000;
   localparam logic [7:0]  BYTE_RESET   = 8'h00;
   localparam logic [31:0] SM_DEFINED   = 32'h0000_006f;
   localparam int SM_LOOP     = 0;
   localparam int SM_RAMP     = 1;
   localparam int SM_BRAKE    = 2;
   localparam int SM_CURRENT_REDUCTION_ENABLE   = 3;
   localparam int SM_TORQUE   = 5;
   localparam int SM_BRUSHLESS_MOTOR_SELECT     = 6;
   localparam int HW_NOSHORT  = 0;
   localparam int XCHG_DEPTH  = 32;
   localparam int DEBUG_DEPTH = 64;
   localparam int STORE_DEPTH = 254;

   // ************************************************************
   // Timing.
   // ************************************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int MS_NS         = 1000000;
   localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

   // ************************************************************
   // Carriers and states.
   // ************************************************************
   typedef struct packed {
      logic        wr;
      logic        pdo;
      logic [15:0] index;
      logic [7:0]  sub;
      logic [31:0] wdata;
   } dorb_req_t;

   typedef struct packed {
      logic        ack;
      logic        err;
      logic [31:0] rdata;
   } dorb_rsp_t;

   typedef enum logic [2:0] {
      RB_IDLE = 3'b001,
      RB_WAIT = 3'b010,
      RB_FIRE = 3'b100
   } dorb_rb_state_t;

endpackage

/* File: src/dorb_word_array.sv */
/*
 * A bank of 32-bit words with a dictionary port and a user program port.
 * Assumes addresses are zero based; out-of-range addresses read zero and
 * writes to them are dropped.
 */
`timescale 1ns/1ps
module dorb_word_array
   import dorb_pkg::*;
#(
   parameter int DEPTH = XCHG_DEPTH,
   parameter int AW    = 5
) (
   input  wire logic          clock_i,
   input  wire logic          reset_i,
   input  wire logic          bus_we_i,
   input  wire logic [AW-1:0] bus_addr_i,
   input  wire logic [31:0]   bus_wdata_i,
   output logic      [31:0]   bus_rdata_o,
   input  wire logic          usr_we_i,
   input  wire logic [AW-1:0] usr_addr_i,
   input  wire logic [31:0]   usr_wdata_i,
   output logic      [31:0]   usr_rdata_o
);

   logic [31:0] mem_ff [DEPTH];

   // Stores words; the dictionary write is last, so it wins a collision.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_ff[i] <= WORD_RESET;
         end
      end else begin
         if (usr_we_i && (int'(usr_addr_i) < DEPTH)) begin
            mem_ff[usr_addr_i] <= usr_wdata_i;
         end
         if (bus_we_i && (int'(bus_addr_i) < DEPTH)) begin
            mem_ff[bus_addr_i] <= bus_wdata_i;
         end
      end
   end

   // Reads both ports straight from the stored words.
   assign bus_rdata_o = (int'(bus_addr_i) < DEPTH) ? mem_ff[bus_addr_i] : WORD_RESET;
   assign usr_rdata_o = (int'(usr_addr_i) < DEPTH) ? mem_ff[usr_addr_i] : WORD_RESET;

endmodule

/* File: src/dorb_reboot_timer.sv */
/*
 * Delays a restart request by a number of milliseconds, then pulses.
 * Assumes a single clock; the millisecond rate is an enable from a divider.
 */
`timescale 1ns/1ps
module dorb_reboot_timer
   import dorb_pkg::*;
#(
   parameter int CYC_MS = CYC_PER_MS
) (
   input  wire logic        clock_i,
   input  wire logic        reset_i,
   input  wire logic        start_i,
   input  wire logic [31:0] delay_ms_i,
   output logic             busy_o,
   output logic             fire_o
);

   localparam int DW = $clog2(CYC_MS + 1);
   localparam logic [DW-1:0] DIV_LAST = DW'(CYC_MS - 1);

   dorb_rb_state_t state_ff;
   logic [31:0]    ms_left_ff;
   logic [DW-1:0]  div_ff;
   logic           tick;

   assign tick = (state_ff == RB_WAIT) && (div_ff == DIV_LAST);

   // Steps the wait; a new start restarts the whole delay.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state_ff <= RB_IDLE;
      end else if (start_i) begin
         state_ff <= RB_WAIT;
      end else begin
         unique case (state_ff)
            RB_IDLE: state_ff <= RB_IDLE;
            RB_WAIT: state_ff <= (ms_left_ff == WORD_RESET) ? RB_FIRE : RB_WAIT;
            RB_FIRE: state_ff <= RB_IDLE;
            default: state_ff <= RB_IDLE;
         endcase
      end
   end

   // Counts whole milliseconds down.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         ms_left_ff <= WORD_RESET;
      end else if (start_i) begin
         ms_left_ff <= delay_ms_i;
      end else if (tick && (ms_left_ff != WORD_RESET)) begin
         ms_left_ff <= ms_left_ff - 32'h0000_0001;
      end
   end

   // Makes the millisecond enable.
   always_ff @(posedge clock_i) begin
      if (reset_i || start_i || (state_ff != RB_WAIT) || tick) begin
         div_ff <= '0;
      end else begin
         div_ff <= div_ff + DW'(1);
      end
   end

   assign busy_o = (state_ff == RB_WAIT);
   assign fire_o = (state_ff == RB_FIRE);

endmodule

/* File: test/dorb_master.sv */
/* Fieldbus master model: presents one dictionary request for each cycle go_i is high.
   Assumes go_i and cmd_i change just after a rising edge of clock_i. */
`timescale 1ns/1ps
module dorb_master
   import dorb_pkg::*;
(
   input  wire logic      clock_i,
   input  wire logic      go_i,
   input  wire dorb_req_t cmd_i,
   output logic           od_req_o,
   output dorb_req_t      od_cmd_o
);
   // ********************
   // Request driver.
   // ********************
   // An idle command bus flips to the inverse of its value each cycle, so every second idle cycle shows the last command again.
   always_ff @(posedge clock_i) begin
      od_req_o <= go_i;
      od_cmd_o <= go_i ? cmd_i : ~od_cmd_o;
   end
endmodule

/* File: test/dorb_bank_test.sv */
/* Self-checking bench of the drive object register bank.
   Assumes the master model and a 4-cycle millisecond for short delays. */
`timescale 1ns/1ps
module dorb_bank_test;
   import dorb_pkg::*;
   logic        clock_i, reset_i, go, od_req, out_we, dbg_push, tq;
   dorb_req_t   cmd, od_cmd;
   dorb_rsp_t   rsp, last;
   logic [4:0]  in_a, init_a, out_a;
   logic [7:0]  st_a, dbg_b;
   logic [31:0] out_d, in_d, init_d, st_d;
   logic        full, rb, rbp, wse, lcs, rse, abe, cre, tqo, bms;
   logic [23:0] tbl [7] = '{24'h2400_01, 24'h2410_05, 24'h2500_20, 24'h2600_01,
                            24'h2701_fe, 24'h2800_02, 24'h3202_00};
   int          err_total, compares, n;
   dorb_master pm (.clock_i(clock_i), .go_i(go), .cmd_i(cmd), .od_req_o(od_req),
                   .od_cmd_o(od_cmd));
   dorb_bank #(.CYC_MS(4)) uut (.clock_i(clock_i), .reset_i(reset_i), .od_req_i(od_req),
      .od_cmd_i(od_cmd), .od_rsp_o(rsp), .prog_in_addr_i(in_a), .prog_in_data_o(in_d),
      .prog_init_addr_i(init_a), .prog_init_data_o(init_d), .prog_out_we_i(out_we),
      .prog_out_addr_i(out_a), .prog_out_data_i(out_d), .prog_store_addr_i(st_a),
      .prog_store_data_o(st_d), .dbg_push_i(dbg_push), .dbg_byte_i(dbg_b),
      .dbg_full_o(full), .reboot_o(rb), .reboot_pending_o(rbp), .winding_short_en_o(wse),
      .torque_mode_i(tq), .loop_closure_select_o(lcs), .ramp_speed_emulation_o(rse),
      .auto_brake_en_o(abe), .current_reduction_enable_o(cre), .torque_only_o(tqo),
      .brushless_motor_select_o(bms));
   // Compares one value and reports a mismatch.
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Runs one dictionary access through the master and keeps the answer.
   task acc(input logic wr, pdo, input logic [15:0] ix, input logic [7:0] sb,
            input logic [31:0] wd);
      go <= 1'b1;
      cmd <= '{wr, pdo, ix, sb, wd};
      @(posedge clock_i) go <= 1'b0;
      n = 0;
      do begin @(posedge clock_i); #1; n++; end while (rsp.ack !== 1'b1 && n < 4);
      last = rsp;
      chk("ack", last.ack, 1'b1);
      @(posedge clock_i);
   endtask
   // Prints the verdict and ends the run.
   task test_done;
      if (err_total == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin clock_i = 0; forever #12.5 clock_i = ~clock_i; end
   initial begin #(4000 * 25); err_total++; test_done; end
   // ********************
   // Test sequence.
   // ********************
   initial begin
      {go, cmd, out_we, dbg_push} = 0;
      reset_i = 1'b1;
      tq = 1'b1;
      {in_a, init_a, out_a, out_d, st_a, dbg_b} = 0;
      repeat (12) @(posedge clock_i);
      reset_i <= 0;
      @(posedge clock_i);
      foreach (tbl[i]) begin
         acc(0, 0, tbl[i][23:8], tbl[i][7:0], 0);
         chk("reset", last.rdata, 32'h0000_0000);
      end
      chk("wse", wse, 1'b1);
      in_a <= 5'h1f;
      acc(1, 1, IDX_INPUTS, XCHG_LAST, 32'h8000_0001);
      chk("in", in_d, 32'h8000_0001);
      acc(1, 1, IDX_INIT, 8'h01, 32'hffff_fffe);
      chk("init", init_d, 32'hffff_fffe);
      go  <= 1'b1;
      cmd <= '{1'b1, 1'b0, IDX_INIT, 8'h01, 32'h0bad_cafe};
      @(posedge clock_i) cmd <= '{1'b0, 1'b0, IDX_INIT, 8'h01, 32'h0000_0000};
      @(posedge clock_i) go <= 1'b0;
      @(posedge clock_i);
      #1 chk("initrd", rsp.rdata, 32'h0bad_cafe);
      @(posedge clock_i);
      out_we <= 1'b1; out_a <= 5'h03; out_d <= 32'h1234_5678;
      @(posedge clock_i) out_we <= 1'b0;
      acc(0, 1, IDX_OUTPUTS, 8'h04, 0);
      chk("out", last.rdata, 32'h1234_5678);
      acc(1, 1, IDX_OUTPUTS, 8'h04, 0);
      chk("outpdo", last.err, 1'b1);
      dbg_push <= 1'b1; dbg_b <= 8'h5a;
      @(posedge clock_i) dbg_push <= 1'b0;
      acc(0, 0, IDX_DEBUG, 8'h01, 0);
      chk("dbg", last.rdata, 32'h0000_005a);
      acc(1, 0, IDX_DEBUG, 8'h01, 0);
      chk("dbgwr", last.err, 1'b1);
      dbg_push <= 1'b1;
      repeat (65) @(posedge clock_i);
      dbg_push <= 1'b0;
      acc(0, 0, IDX_DEBUG, SUB_COUNT, 0);
      chk("dbgfill", last.rdata, 32'h0000_0040);
      chk("full", full, 1'b1);
      acc(1, 0, IDX_DEBUG, SUB_COUNT, 0);
      chk("dbgcnt", last.err, 1'b0);
      chk("notfull", full, 1'b0);
      st_a <= 8'hfd;
      acc(1, 0, IDX_STORE, STORE_LAST, 32'hcafe_0001);
      chk("store", st_d, 32'hcafe_0001);
      acc(0, 0, IDX_STORE, 8'hff, 0);
      chk("storeff", last.err, 1'b1);
      acc(0, 0, 16'h2401, 8'h01, 0);
      chk("unmapped", last.err, 1'b1);
      acc(1, 1, IDX_SUBMODE, SUB_COUNT, 32'hffff_ffff);
      chk("sm", {cre, tqo, bms, lcs, rse, abe}, 6'b01_1111);
      tq <= 1'b0;
      @(posedge clock_i);
      chk("tqoff", tqo, 1'b0);
      acc(0, 0, IDX_SUBMODE, SUB_COUNT, 0);
      chk("smrd", last.rdata, SM_DEFINED);
      acc(1, 0, IDX_SUBMODE, SUB_COUNT, 32'h0000_0008);
      chk("current_reduction_enable", {cre, tqo, bms, lcs}, 4'b1000);
      acc(1, 0, IDX_REBOOT, SUB_RB_HW, 32'h0000_0001);
      chk("wse", wse, 1'b0);
      acc(1, 0, IDX_REBOOT, SUB_RB_CMD, 32'h746f_6f63);
      chk("nomagic", {rb, rbp}, 2'b00);
      acc(0, 0, IDX_REBOOT, SUB_RB_CMD, 0);
      chk("cmdrd", last.rdata, 32'h746f_6f63);
      acc(1, 0, IDX_REBOOT, SUB_RB_DELAY, 32'h0000_0002);
      acc(1, 0, IDX_REBOOT, SUB_RB_CMD, REBOOT_MAGIC);
      #1;
      chk("pending", rbp, 1'b1);
      n = 1;
      while (rb !== 1'b1 && n < 40) begin @(posedge clock_i); #1; n++; end
      chk("delay", n, 9);
      @(posedge clock_i);
      acc(1, 0, IDX_REBOOT, SUB_RB_DELAY, 32'h0000_0000);
      acc(1, 0, IDX_REBOOT, SUB_RB_CMD, REBOOT_MAGIC);
      #1 chk("fire0", {rb, rbp}, 2'b10);
      @(posedge clock_i) reset_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      reset_i <= 1'b0;
      @(posedge clock_i);
      acc(0, 0, IDX_STORE, STORE_LAST, 0);
      chk("rst2", last.rdata, 32'h0000_0000);
      chk("rst2pins", {wse, full, st_d[0]}, 3'b100);
      test_done;
   end
endmodule
